// ===== core/gfd_pkg.sv
// Functional notes
// (RQ1) fault input acts only when enabled
// (RQ2) input deassert shuts the selected rails
// (RQ3) fault shutdown latches, never retries
// (RQ4) debug blocks alert and fault responses
// (RQ5) debug covers all listed rail events
// (RQ6) debug ignores sequencing dependencies
// (RQ7) debug switches rail on timeout expiry
// (RQ8) debug zero timeout switches rail at once
// (RQ9) debug keeps fault bus pin released
// (RQ10) debug entry restores event-changed outputs
// (RQ11) debug input deassert: no log, no response
// (RQ12) rail fault drives fault bus low; the code pulls it only while gfe_r is set
// (RQ13) fault cleared releases fault bus pin
// (RQ14) assertion follows polarity after glitch filter
package gfd_pkg;
  // -------------------------------------------------
  // timing
  // -------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int GLITCH_NS     = 1000;
  // least time, rounded up to whole cycles
  localparam int GLITCH_CYC    =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // -------------------------------------------------
  // sizes
  // -------------------------------------------------
  localparam int GPI_NUM  = 8;
  localparam int RAIL_NUM = 16;
  localparam int LDRV_NUM = 8;
  localparam int EVT_NUM  = 11;
  localparam int SEL_W    = 3;
  // -------------------------------------------------
  // register byte offsets
  // -------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_POL   = 8'h04;
  localparam logic [7:0] OFS_FILT  = 8'h08;
  localparam logic [7:0] OFS_SMASK = 8'h0c;
  localparam logic [7:0] OFS_RMASK = 8'h10;
  localparam logic [7:0] OFS_FPIN  = 8'h14;
  localparam logic [7:0] OFS_STS   = 8'h18;
  localparam logic [7:0] OFS_IMASK = 8'h1c;
  localparam logic [7:0] OFS_STATE = 8'h20;
  localparam logic [7:0] OFS_LDRV  = 8'h24;
  localparam logic [7:0] OFS_SHUT  = 8'h28;
  // -------------------------------------------------
  // field positions
  // -------------------------------------------------
  localparam int CTRL_GFE  = 0;
  localparam int CTRL_DBE  = 1;
  localparam int CTRL_FSEL = 4;
  localparam int CTRL_DSEL = 8;
  localparam int LG_BASE   = 0;
  localparam int LG_VAL    = 8;
  localparam int LG_MSK    = 16;
  localparam int SHUT_CLR  = 0;
  localparam int LGF_CLR   = 1;
  localparam int ST_RAIL   = 16;
  localparam int ST_DBG    = 15;
  localparam int ST_BUS    = 14;
  // status bits: events 0..10, then these
  localparam int STS_GSHUT = 11;
  localparam int STS_DBG   = 12;
  localparam int STS_W     = 13;
  // -------------------------------------------------
  // reset values
  // -------------------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage

// ===== core/gfd_in_cond.sv
`timescale 1ns/100ps
// two-flop synchroniser plus optional glitch filter per input
module gfd_in_cond
  import gfd_pkg::*;
#(
  parameter int W    = GPI_NUM,
  parameter int FCYC = GLITCH_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] filt_en,
  output logic      [W-1:0] level_o
);
  localparam int CW = $clog2(FCYC + 1);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_in
      logic          s1_r;   // first stage, read by s2 only
      logic          s2_r;   // synchronised sample
      logic [CW-1:0] cnt_r;  // stable-cycle count
      logic          lvl_r;  // filtered level
      // ---------------------------------------------
      // sync and filter
      // ---------------------------------------------
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          cnt_r <= '0;
          lvl_r <= 1'b0;
        end else if (ce) begin
          s1_r <= pin_i[g];
          s2_r <= s1_r;
          // unfiltered: follow sync output
          if (!filt_en[g]) begin
            lvl_r <= s2_r;
            cnt_r <= '0;
          end else if (s2_r != lvl_r) begin
            // change accepted only after FCYC steady cycles
            if (cnt_r == CW'(FCYC - 1)) begin
              lvl_r <= s2_r;
              cnt_r <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end else begin
            cnt_r <= '0;
          end
        end
      end
      assign level_o[g] = lvl_r;
    end
  endgenerate
endmodule // gfd_in_cond

// ===== core/gfd_fault_pin.sv
`timescale 1ns/100ps
// open-drain fault bus pin: listens, or pulls low on request
module gfd_fault_pin (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic drive_req,
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_n,
  output logic      bus_low_o
);
  logic s1_r;     // first sync stage
  logic s2_r;     // synchronised bus level
  logic oe_n_r;   // low while pulling the bus
  // ---------------------------------------------
  // drive and listen
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      oe_n_r <= 1'b1;
    end else if (ce) begin
      s1_r   <= pin_i;
      s2_r   <= s1_r;
      oe_n_r <= ~drive_req;
    end
  end
  // open drain: only ever drives zero
  assign pin_o     = 1'b0;
  assign pin_oe_n  = oe_n_r;
  assign bus_low_o = ~s2_r;
endmodule // gfd_fault_pin

// ===== core/gfd_top.sv
`timescale 1ns/100ps
// gpi fault shutdown and sequencing debug mode controller
module gfd_top
  import gfd_pkg::*;
#(
  parameter int NGPI  = GPI_NUM,
  parameter int NRAIL = RAIL_NUM,
  parameter int NLG   = LDRV_NUM,
  parameter int FCYC  = GLITCH_CYC
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  // general inputs from pins
  input  wire logic [NGPI-1:0]  gpi_pin,
  // rail events, one-cycle pulses, same clock
  input  wire logic [EVT_NUM-1:0] evt_i,
  input  wire logic [NRAIL-1:0] rail_fault_i,
  // sequencing inputs, same clock
  input  wire logic [NRAIL-1:0] rail_req_i,
  input  wire logic [NRAIL-1:0] dep_ok_i,
  input  wire logic [NRAIL-1:0] tmo_exp_i,
  input  wire logic [NRAIL-1:0] tmo_zero_i,
  output logic      [NRAIL-1:0] rail_en_o,
  output logic      [NLG-1:0]   logic_driven_output,
  // open-drain fault bus pin
  input  wire logic             fault_pin_i,
  output logic                  fault_pin_o,
  output logic                  fault_pin_oe_n,
  output logic                  alert_n,
  output logic                  irq
);
  // -------------------------------------------------
  // configuration and state registers
  // -------------------------------------------------
  logic             gfe_r;      // input fault enable
  logic             dbe_r;      // debug function enable
  logic [SEL_W-1:0] fsel_r;     // fault input select
  logic [SEL_W-1:0] dsel_r;     // debug input select
  logic [NGPI-1:0]  pol_r;      // 1: input active low
  logic [NGPI-1:0]  fen_r;      // glitch filter enables
  logic [NRAIL-1:0] smask_r;    // rails shut by input fault
  logic [NRAIL-1:0] rmask_r;    // rails shut on own fault
  logic [NRAIL-1:0] fpmask_r;   // rails that pull fault bus
  logic [STS_W-1:0] sts_r;      // sticky status
  logic [STS_W-1:0] imask_r;    // interrupt mask
  logic [NLG-1:0]   lg_base_r;  // normal output values
  logic [NLG-1:0]   lg_val_r;   // values forced by events
  logic [NLG-1:0]   lg_msk_r;   // outputs events may change
  logic [NLG-1:0]   lg_force_r; // outputs currently forced
  logic [NLG-1:0]   lg_out_r;   // output flops
  logic [NRAIL-1:0] shut_r;     // latched shutdown
  logic [NRAIL-1:0] rail_seq_r; // sequencer target state
  logic [NRAIL-1:0] rail_en_r;  // enable output flops
  logic [NGPI-1:0]  gpi_q_r;    // previous asserted state
  logic             debug_r;    // debug mode active
  logic             irq_r;
  logic             alert_n_r;
  // bus pipeline
  logic             wr_r;       // data phase is a write
  logic [7:0]       addr_r;     // data phase address
  logic [31:0]      rdata_r;    // read data flops

  // -------------------------------------------------
  // input conditioning and fault pin
  // -------------------------------------------------
  logic [NGPI-1:0]  gpi_filt;   // synced, filtered level
  logic [NGPI-1:0]  gpi_asrt;   // asserted, polarity applied
  logic             bus_low;    // shared fault bus low
  logic             drive_req;  // pull the fault bus

  gfd_in_cond #(
    .W    (NGPI),
    .FCYC (FCYC)
  ) u_in (
    .clk     (hclk),
    .rst_n   (hresetn),
    .ce      (clk_en),
    .pin_i   (gpi_pin),
    .filt_en (fen_r),
    .level_o (gpi_filt)
  );

  gfd_fault_pin u_fp (
    .clk       (hclk),
    .rst_n     (hresetn),
    .ce        (clk_en),
    .drive_req (drive_req),
    .pin_i     (fault_pin_i),
    .pin_o     (fault_pin_o),
    .pin_oe_n  (fault_pin_oe_n),
    .bus_low_o (bus_low)
  );

  // (RQ14) polarity after filter
  assign gpi_asrt = gpi_filt ^ pol_r;

  // -------------------------------------------------
  // ahb-lite decode
  // -------------------------------------------------
  // freezing the clock enable also stalls the bus
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  wire ap_go  = hsel & htrans[1] & hready & clk_en;
  wire wr_go  = wr_r & clk_en;
  wire w_ctrl = wr_go & (addr_r == OFS_CTRL);
  wire w_pol  = wr_go & (addr_r == OFS_POL);
  wire w_filt = wr_go & (addr_r == OFS_FILT);
  wire w_smsk = wr_go & (addr_r == OFS_SMASK);
  wire w_rmsk = wr_go & (addr_r == OFS_RMASK);
  wire w_fpin = wr_go & (addr_r == OFS_FPIN);
  wire w_sts  = wr_go & (addr_r == OFS_STS);
  wire w_imsk = wr_go & (addr_r == OFS_IMASK);
  wire w_ldrv = wr_go & (addr_r == OFS_LDRV);
  wire w_shut = wr_go & (addr_r == OFS_SHUT);
  wire [7:0] ra = {haddr[7:2], 2'b00};
  // read mux; unmapped addresses read zero
  wire [31:0] rd_mux =
    (ra == OFS_CTRL)  ? {20'h0, 1'b0, dsel_r, 1'b0, fsel_r,
                         2'b00, dbe_r, gfe_r} :
    (ra == OFS_POL)   ? 32'(pol_r)    :
    (ra == OFS_FILT)  ? 32'(fen_r)    :
    (ra == OFS_SMASK) ? 32'(smask_r)  :
    (ra == OFS_RMASK) ? 32'(rmask_r)  :
    (ra == OFS_FPIN)  ? 32'(fpmask_r) :
    (ra == OFS_STS)   ? 32'(sts_r)    :
    (ra == OFS_IMASK) ? 32'(imask_r)  :
    (ra == OFS_STATE) ? {16'(rail_en_r), debug_r, bus_low,
                         6'h00, 8'(gpi_asrt)} :
    (ra == OFS_LDRV)  ? {8'h00, 8'(lg_msk_r), 8'(lg_val_r),
                         8'(lg_base_r)} :
    (ra == OFS_SHUT)  ? 32'(shut_r)   : RST_ZERO;

  // -------------------------------------------------
  // event logic
  // -------------------------------------------------
  // (RQ11) debug input still works in debug
  wire debug_nxt = dbe_r & gpi_asrt[dsel_r];
  wire dbg_rise  = debug_nxt & ~debug_r;
  // fault input falls from asserted to deasserted
  wire fault_deasrt = gpi_q_r[fsel_r] & ~gpi_asrt[fsel_r];
  // (RQ1) gated by fault enable
  // (RQ11) no fault response while in debug
  wire gshut_set = gfe_r & ~debug_r & fault_deasrt;
  // (RQ4) (RQ5) all listed events masked in debug
  wire [EVT_NUM-1:0] evt_set = debug_r ? '0 : evt_i;
  wire [NRAIL-1:0] rail_hit =
    debug_r ? '0 : (rail_fault_i & rmask_r);
  // (RQ2) input fault shuts the selected rails
  wire [NRAIL-1:0] shut_set =
    (gshut_set ? smask_r : '0) | rail_hit;
  // (RQ3) latched until software clears it, no retry
  wire shut_clr = w_shut & hwdata[SHUT_CLR];
  wire [NRAIL-1:0] shut_nxt =
    (shut_clr ? '0 : shut_r) | shut_set;
  // status: set wins over write-one-to-clear
  wire [STS_W-1:0] sts_set = {dbg_rise, gshut_set, evt_set};
  wire [STS_W-1:0] sts_w1c = w_sts ? hwdata[STS_W-1:0] : '0;
  wire [STS_W-1:0] sts_nxt = (sts_r & ~sts_w1c) | sts_set;

  // -------------------------------------------------
  // rail sequencing
  // -------------------------------------------------
  // (RQ6) debug ignores dependencies
  // (RQ7) (RQ8) expiry or zero timeout switches rail
  wire [NRAIL-1:0] seq_go =
    debug_r ? (tmo_exp_i | tmo_zero_i) : dep_ok_i;
  wire [NRAIL-1:0] seq_nxt =
    rail_seq_r ^ ((rail_req_i ^ rail_seq_r) & seq_go);

  // -------------------------------------------------
  // logic driven outputs
  // -------------------------------------------------
  // (RQ10) debug entry drops forcing, base returns
  wire lg_clr = w_shut & hwdata[LGF_CLR];
  // an event in the same cycle as a software clear wins
  wire [NLG-1:0] lg_force_nxt =
    debug_nxt ? '0 :
    ((lg_clr ? '0 : lg_force_r) | ((|evt_set) ? lg_msk_r : '0));
  wire [NLG-1:0] lg_out_nxt =
    (lg_val_r & lg_force_nxt) | (lg_base_r & ~lg_force_nxt);

  // -------------------------------------------------
  // fault bus request
  // -------------------------------------------------
  // (RQ12) (RQ13) pull while a selected rail faults and gfe_r is set
  // (RQ9) debug keeps the pin released
  assign drive_req =
    gfe_r & ~debug_r & (|(rail_fault_i & fpmask_r));

  // -------------------------------------------------
  // bus pipeline flops
  // -------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r    <= 1'b0;
      addr_r  <= 8'h00;
      rdata_r <= RST_ZERO;
    end else if (clk_en) begin
      wr_r    <= ap_go & hwrite;
      addr_r  <= {haddr[7:2], 2'b00};
      // sampled at the address phase, one data phase
      if (ap_go && !hwrite) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // -------------------------------------------------
  // software written configuration
  // -------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gfe_r    <= 1'b0;
      dbe_r    <= 1'b0;
      fsel_r   <= '0;
      dsel_r   <= '0;
      pol_r    <= '0;
      fen_r    <= '0;
      smask_r  <= '0;
      rmask_r  <= '0;
      fpmask_r <= '0;
      imask_r  <= '0;
    end else if (clk_en) begin
      if (w_ctrl) begin
        gfe_r  <= hwdata[CTRL_GFE];
        dbe_r  <= hwdata[CTRL_DBE];
        fsel_r <= hwdata[CTRL_FSEL +: SEL_W];
        dsel_r <= hwdata[CTRL_DSEL +: SEL_W];
      end
      if (w_pol)  pol_r    <= hwdata[NGPI-1:0];
      if (w_filt) fen_r    <= hwdata[NGPI-1:0];
      if (w_smsk) smask_r  <= hwdata[NRAIL-1:0];
      if (w_rmsk) rmask_r  <= hwdata[NRAIL-1:0];
      if (w_fpin) fpmask_r <= hwdata[NRAIL-1:0];
      if (w_imsk) imask_r  <= hwdata[STS_W-1:0];
    end
  end

  // logic driven output settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lg_base_r <= '0;
      lg_val_r  <= '0;
      lg_msk_r  <= '0;
    end else if (clk_en && w_ldrv) begin
      lg_base_r <= hwdata[LG_BASE +: NLG];
      lg_val_r  <= hwdata[LG_VAL +: NLG];
      lg_msk_r  <= hwdata[LG_MSK +: NLG];
    end
  end

  // -------------------------------------------------
  // block state
  // -------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_r    <= 1'b0;
      gpi_q_r    <= '0;
      sts_r      <= '0;
      shut_r     <= '0;
      rail_seq_r <= '0;
      rail_en_r  <= '0;
      lg_force_r <= '0;
      lg_out_r   <= '0;
      irq_r      <= 1'b0;
      alert_n_r  <= 1'b1;
    end else if (clk_en) begin
      debug_r    <= debug_nxt;
      gpi_q_r    <= gpi_asrt;
      sts_r      <= sts_nxt;
      shut_r     <= shut_nxt;
      rail_seq_r <= seq_nxt;
      // latched shutdown overrides the sequencer
      rail_en_r  <= seq_nxt & ~shut_nxt;
      lg_force_r <= lg_force_nxt;
      lg_out_r   <= lg_out_nxt;
      irq_r      <= |(sts_nxt & imask_r);
      // (RQ4) no alert while debug is active
      alert_n_r  <= ~((|sts_nxt[EVT_NUM-1:0]) & ~debug_nxt);
    end
  end

  assign rail_en_o           = rail_en_r;
  assign logic_driven_output = lg_out_r;
  assign irq                 = irq_r;
  assign alert_n             = alert_n_r;

  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  property p_rq1;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    !gfe_r |=> ((shut_r & ~$past(shut_r)) == '0) ||
               $past(|rail_hit);
  endproperty
  a_rq1: assert property (p_rq1) // RQ1
    else $error("shutdown while fault input disabled");

  property p_rq2;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    gshut_set |=> ((shut_r & $past(smask_r)) == $past(smask_r));
  endproperty
  a_rq2: assert property (p_rq2) // RQ2
    else $error("selected rails not shut on input fault");

  property p_rq3;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    !shut_clr |=> ((shut_r & $past(shut_r)) == $past(shut_r))
                  and ((rail_en_o & $past(shut_r)) == '0);
  endproperty
  a_rq3: assert property (p_rq3) // RQ3
    else $error("shut rail restarted without clear");

  property p_rq4;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    debug_r && debug_nxt |=> alert_n && ($past(rail_hit) == '0);
  endproperty
  a_rq4: assert property (p_rq4) // RQ4
    else $error("alert or response in debug mode");

  property p_rq5;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    debug_r && (sts_r[EVT_NUM-1:0] == '0) && !w_sts
      |=> (sts_r[EVT_NUM-1:0] == '0);
  endproperty
  a_rq5: assert property (p_rq5) // RQ5
    else $error("event logged in debug mode");

  property p_rq7;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    debug_r |=>
      (((rail_seq_r ^ $past(rail_req_i)) & $past(tmo_exp_i)) == '0);
  endproperty
  a_rq7: assert property (p_rq7) // RQ7
    else $error("rail not switched on timeout expiry");

  property p_rq8;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    debug_r |=>
      (((rail_seq_r ^ $past(rail_req_i)) & $past(tmo_zero_i)) == '0);
  endproperty
  a_rq8: assert property (p_rq8) // RQ8
    else $error("zero timeout rail not switched");

  property p_rq9;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    debug_r ##1 clk_en |-> fault_pin_oe_n;
  endproperty
  a_rq9: assert property (p_rq9) // RQ9
    else $error("fault bus driven in debug mode");

  property p_rq10;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    $rose(debug_r) |-> logic_driven_output == $past(lg_base_r);
  endproperty
  a_rq10: assert property (p_rq10) // RQ10
    else $error("outputs not restored on debug entry");

  property p_rq12;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    drive_req |=> !fault_pin_oe_n && !fault_pin_o;
  endproperty
  a_rq12: assert property (p_rq12) // RQ12
    else $error("fault bus not pulled on rail fault");

  property p_rq13;
    @(posedge hclk) disable iff (!hresetn || !clk_en)
    !drive_req |=> fault_pin_oe_n;
  endproperty
  a_rq13: assert property (p_rq13) // RQ13
    else $error("fault bus pin not released");
endmodule // gfd_top

// ===== verif/gfd_far_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// far side: input sources and a peer on the bus
// ---------------------------------------------
module gfd_far_model (
  input  wire logic       hclk,
  input  wire logic [7:0] gpi_set,    // wanted input levels
  input  wire logic       peer_pull,  // peer pulls the bus low
  input  wire logic       dut_oe_n,   // block pulls when low
  output logic      [7:0] gpi_pin,    // driven input pins
  output logic            bus         // resolved fault bus
);
  // pull-up wins only when nobody pulls low
  assign bus = ~(peer_pull | ~dut_oe_n);
  // external logic changes just after the edge
  always_ff @(posedge hclk) begin
    gpi_pin <= gpi_set;
  end
endmodule // gfd_far_model

// ===== verif/gfd_top_test.sv
`timescale 1ns/100ps
// ---------------------------------------------
// self-checking bench
// ---------------------------------------------
module gfd_top_test;
  import gfd_pkg::*;
  logic        hclk = 0, hresetn = 0;   // clock, reset
  logic [31:0] haddr = 0, hwdata = 0;   // bus address, data
  logic [1:0]  htrans = 0;              // idle at start
  logic        hwrite = 0, hreadyout;   // direction, ready
  logic [31:0] hrdata, r;               // read data
  logic [7:0]  gpi_set = 8'h03, gpi_pin, lgo;
  logic [10:0] evt_i = 0;               // event pulses
  logic [15:0] rf = 0, req = 16'hffff, dep = 16'hffff;
  logic [15:0] texp = 0, tz = 0, rail_en;
  logic        peer = 0, bus, oe_n, alert_n, irq;
  logic        ce = 1, hresp, fpo;          // enable, response, pin
  int          n_fail = 0, checked = 0;
  always #4 hclk = ~hclk;
  gfd_far_model gfd_far_model_inst (.hclk(hclk), .gpi_set(gpi_set),
    .peer_pull(peer), .dut_oe_n(oe_n), .gpi_pin(gpi_pin), .bus(bus));
  // short glitch count keeps runs quick
  gfd_top #(.FCYC(2)) gfd_top_inst (.hclk(hclk), .hresetn(hresetn),
    .clk_en(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .gpi_pin(gpi_pin), .evt_i(evt_i),
    .rail_fault_i(rf), .rail_req_i(req), .dep_ok_i(dep),
    .tmo_exp_i(texp), .tmo_zero_i(tz), .rail_en_o(rail_en),
    .logic_driven_output(lgo), .fault_pin_i(bus), .fault_pin_o(fpo),
    .fault_pin_oe_n(oe_n), .alert_n(alert_n), .irq(irq));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cy(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // bounded wait for hready at an edge
  task hrdy;
    int i;
    i = 0;
    do begin @(posedge hclk); i++; end
    while (hreadyout !== 1'b1 && i < 20);
    if (i >= 20) begin n_fail++; end_sim; end
  endtask
  task xf(input logic w, input logic [31:0] a, d);
    haddr <= a; hwrite <= w; htrans <= 2'b10;
    hrdy;
    htrans <= 2'b00; hwdata <= d;
    hrdy;
    r = hrdata;  // taken at the completing edge
  endtask
  task ck(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xf(0, {24'h0, a}, 0);
    ck(nm, e, r);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  // input fault: enable gate, shutdown, no retry
  task t_infault;
    xf(1, OFS_SMASK, 32'h3);
    gpi_set <= 8'h02; cy(8);
    rc("sts off", OFS_STS, 0);
    gpi_set <= 8'h03; cy(8);
    xf(1, OFS_CTRL, 32'h1);
    // one-cycle glitch on the filtered fault input is dropped
    xf(1, OFS_FILT, 32'h1);
    gpi_set <= 8'h02; cy(1);
    gpi_set <= 8'h03; cy(8);
    ck("glitch", 32'hffff, rail_en);
    gpi_set <= 8'h02; cy(8);
    ck("rails", 32'hfffc, rail_en);
    rc("sts on", OFS_STS, 32'h800);
    gpi_set <= 8'h03; cy(8);
    ck("no retry", 32'hfffc, rail_en);
    xf(1, OFS_SHUT, 32'h1); cy(2);
    ck("restored", 32'hffff, rail_en);
    xf(1, OFS_STS, 32'h800);
  endtask
  // own rail fault pulls the bus, then lets go
  task t_bus;
    xf(1, OFS_FPIN, 32'h1);
    rf <= 16'h1; cy(3);
    ck("oe pull", 0, oe_n);
    rf <= 16'h0; cy(3);
    ck("oe free", 1, oe_n);
    peer <= 1; cy(4);
    xf(0, OFS_STATE, 0);
    ck("bus low", 32'h4000, r & 32'h4000);
    peer <= 0;
  endtask
  // event logging, alert, irq, forced outputs
  task t_evt;
    xf(1, OFS_LDRV, 32'h00ff_a55a);
    xf(1, OFS_IMASK, 32'h1);
    // frozen clock enable: the pulse is not taken
    ce <= 0; evt_i <= 11'h001; cy(1);
    evt_i <= 0; cy(2);
    ck("stall", 0, hreadyout);
    ck("frozen", 1, alert_n);
    ce <= 1;
    evt_i <= 11'h001; cy(1);
    evt_i <= 0; cy(3);
    ck("alert", 0, alert_n);
    ck("irq", 1, irq);
    ck("forced", 32'ha5, lgo);
    xf(1, OFS_STS, 32'h1); cy(3);
    ck("irq clr", 0, irq);
  endtask
  // debug mode entered through an active-low pin
  task t_debug;
    xf(1, OFS_RMASK, 32'h1);
    xf(1, OFS_POL, 32'h2);
    xf(1, OFS_CTRL, 32'h103);
    gpi_set <= 8'h01; cy(8);
    ck("lg back", 32'h5a, lgo);
    rf <= 16'h1; evt_i <= 11'h7ff; gpi_set <= 8'h00; cy(1);
    evt_i <= 0; cy(8);
    ck("oe dbg", 1, oe_n);
    ck("alert dbg", 1, alert_n);
    ck("rails dbg", 32'hffff, rail_en);
    rc("sts dbg", OFS_STS, 32'h1000);
    dep <= 0; req <= 16'h7fff; tz <= 16'h8000; cy(3);
    ck("zero tmo", 32'h7fff, rail_en);
    req <= 16'h3fff; texp <= 16'h4000; cy(1);
    texp <= 0; cy(2);
    ck("tmo exp", 32'h3fff, rail_en);
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    cy(2);
    hresetn <= 1;
    cy(1);
    ck("oe rst", 1, oe_n);
    ck("okay pins", 0, {hresp, fpo});
    rc("unmapped", 8'hfc, 0);
    t_infault;
    t_bus;
    t_evt;
    t_debug;
    end_sim;
  end
endmodule // gfd_top_test
